// file: verification/parallel_result_output_sequencer_tb.sv
// Purpose: self-checking bench of the result output sequencer
// Assumes: gate delay 3, width 5, cycle 40, queue depth 4
// Notes: bus and monitor sample at the falling edge
`timescale 1ns/1ps
`include "pros_params.svh"
module parallel_result_output_sequencer_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic go = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic adjustment_mode = 1'b0;
  logic image_done = 1'b0;
  logic measure_done = 1'b0;
  logic display_done = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, meas_start, overall_out, gate_out, queue_full, measure_trigger, cap_valid, cap_moved;
  logic [15:0] result_word_out, cap_word, cap_wid, cap_per;
  int err_count = 0;
  int tests_run = 0;
  int ms_cnt = 0;
  logic qf_seen = 1'b0;
  logic [15:0] exp_q[$], got_q[$], wid_q[$], per_q[$];
  logic mov_q[$];
  logic [31:0] vals[32];
  logic [31:0] dcfg, jcfg, jng;
  logic [4:0] sen, sng;
  logic exp_ov;
  pros_sequencer #(.QDEPTH(4)) pros_sequencer_inst (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .measure_trigger(measure_trigger), .adjustment_mode(adjustment_mode),
    .image_done(image_done), .measure_done(measure_done), .display_done(display_done), .meas_start(meas_start),
    .result_word_out(result_word_out), .overall_out(overall_out), .gate_out(gate_out), .queue_full(queue_full));
  pros_plc_model #(.HOLD(8)) pros_plc_model_inst (.clk(clk), .reset(reset), .go(go),
    .measure_trigger(measure_trigger), .result_word_out(result_word_out), .gate_out(gate_out),
    .cap_valid(cap_valid), .cap_word(cap_word), .cap_wid(cap_wid), .cap_per(cap_per), .cap_moved(cap_moved));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (meas_start === 1'b1) ms_cnt++;
    if (queue_full === 1'b1) qf_seen = 1'b1;
    if (cap_valid === 1'b1) begin
      got_q.push_back(cap_word);
      wid_q.push_back(cap_wid);
      per_q.push_back(cap_per);
      mov_q.push_back(cap_moved);
    end
  end
  task automatic give_verdict;
    $display("mismatches %0d, comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic timeout;
    err_count++;
    $display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
    give_verdict();
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) timeout();
      @(negedge clk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    hsize <= `PROS_HSIZE_WORD;
    wait_rdy();
    @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  function automatic logic [15:0] sat(input logic [31:0] v);
    logic signed [32:0] t;
    t = ($signed({v[31], v}) + 33'sh0_0000_8000) >>> 16;
    if (t > 33'sh0_0000_7FFF) return 16'h7FFF;
    if (t < -33'sh0_0000_8000) return 16'h8000;
    return t[15:0];
  endfunction
  task automatic run_meas(input pros_pkg::pros_ctrl_t c);
    logic [31:0] jw;
    int n;
    wr(`PROS_OFS_CTRL, {26'h000_0000, c});
    wr(`PROS_OFS_DCFG, dcfg);
    wr(`PROS_OFS_JCFG, jcfg);
    wr(`PROS_OFS_JNG, jng);
    wr(`PROS_OFS_SRCEN, {27'h000_0000, sen});
    wr(`PROS_OFS_SRCNG, {27'h000_0000, sng});
    for (int i = 0; i < 32; i++) wr(8'h80 + 8'(4 * i), vals[i]);
    jw = jcfg & (c.judge_on_ok ? ~jng : jng);
    exp_q = {};
    if (c.data_en) for (int i = 0; i < 32; i++) if (dcfg[i]) exp_q.push_back(sat(vals[i]));
    if (c.judge_en && jcfg[15:0] != 16'h0000) exp_q.push_back(jw[15:0]);
    if (c.judge_en && jcfg[31:16] != 16'h0000) exp_q.push_back(jw[31:16]);
    exp_ov = c.overall_on_ok ? ~|(sen & sng) : |(sen & sng);
    got_q = {};
    wid_q = {};
    per_q = {};
    mov_q = {};
    n = ms_cnt;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int k = 0; k < 100 && ms_cnt == n; k++) @(posedge clk);
    if (ms_cnt == n) timeout();
    for (int k = 0; k < 3; k++) begin
      {display_done, measure_done, image_done} <= 3'b001 << k;
      @(posedge clk);
      {display_done, measure_done, image_done} <= 3'b000;
      repeat (3) @(posedge clk);
    end
    chk_reg({31'h0, overall_out}, {31'h0, exp_ov});
    for (n = 0; got_q.size() < exp_q.size(); n++) begin
      if (n > 3000) timeout();
      @(posedge clk);
    end
    repeat (80) @(posedge clk);
    chk_reg(got_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got_q.size()) begin
      chk_word(got_q[i], exp_q[i]);
      chk_word(wid_q[i], 16'h0005);
      chk_reg({31'h0, mov_q[i]}, 32'h0000_0000);
      if (i > 0) chk_word(per_q[i], 16'h0028);
    end
  endtask
  initial begin
    logic [7:0] ra[7];
    logic [31:0] rv[7];
    logic [31:0] r;
    logic [15:0] w;
    logic o;
    int n;
    ra = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1C, 8'h20, 8'h40};
    rv = '{32'h0000_0013, 32'h0000_001F, 32'h0000_0000, 32'h0000_0064, 32'h0000_00C8, 32'h0000_01F4, 32'h0000_0000};
    void'($urandom(32'h6dc9_b173));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ra[i], 32'h0000_0000, r);
      chk_reg(r, rv[i]);
      chk_reg({31'h0, hresp}, 32'h0000_0000);
    end
    chk_word(result_word_out, 16'h0000);
    wr(`PROS_OFS_GDLY, 32'h0000_0003);
    wr(`PROS_OFS_GWID, 32'h0000_0005);
    wr(`PROS_OFS_OCYC, 32'h0000_0028);
    foreach (vals[i]) vals[i] = $urandom;
    vals[0:5] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h0000_8000, 32'hFFFF_7FFF, 32'h04D2_0000, 32'hFB2E_0000};
    dcfg = 32'h8000_003F;
    jcfg = 32'h0001_0000;
    jng = $urandom;
    sen = 5'h1F;
    sng = 5'h04;
    n = ms_cnt;
    run_meas(pros_pkg::pros_ctrl_t'(6'h13));
    chk_reg(ms_cnt - n, 32'h0000_0001);
    chk_reg({31'h0, qf_seen}, 32'h0000_0001);
    w = result_word_out;
    o = overall_out;
    n = ms_cnt;
    adjustment_mode <= 1'b1;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (60) @(posedge clk);
    chk_reg(ms_cnt - n, 32'h0000_0000);
    chk_word(result_word_out, w);
    chk_reg({31'h0, overall_out}, {31'h0, o});
    adjustment_mode <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      foreach (vals[i]) vals[i] = $urandom;
      dcfg = $urandom;
      jcfg = $urandom;
      jng = $urandom;
      sen = 5'($urandom);
      sng = 5'($urandom);
      run_meas(pros_pkg::pros_ctrl_t'(6'($urandom)));
    end
    give_verdict();
  end
endmodule

// file: verification/pros_plc_model.sv
// Purpose: far-side controller model, trigger pulses and gated capture
// Assumes: trigger hold shortened by HOLD to keep the run short
// Notes: one capture report per gate pulse, one cycle after it falls
`timescale 1ns/1ps
module pros_plc_model #(
  parameter int HOLD = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  output logic measure_trigger,
  input wire logic [15:0] result_word_out,
  input wire logic gate_out,
  output logic cap_valid,
  output logic [15:0] cap_word,
  output logic [15:0] cap_wid,
  output logic [15:0] cap_per,
  output logic cap_moved
);
  logic [15:0] hold_q;
  logic gate_q;
  logic [15:0] per_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_q <= 16'h0000;
    end else if (go) begin
      hold_q <= HOLD[15:0];
    end else if (hold_q != 16'h0000) begin
      hold_q <= hold_q - 16'h0001;
    end
  end
  assign measure_trigger = hold_q != 16'h0000;
  // Word taken at gate rise, watched for movement while high
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_q <= 1'b0;
      cap_valid <= 1'b0;
      per_q <= 16'h0000;
    end else begin
      gate_q <= gate_out;
      cap_valid <= 1'b0;
      per_q <= per_q + 16'h0001;
      if (gate_out && !gate_q) begin
        cap_word <= result_word_out;
        cap_wid <= 16'h0001;
        cap_moved <= 1'b0;
        cap_per <= per_q;
        per_q <= 16'h0001;
      end else if (gate_out) begin
        cap_wid <= cap_wid + 16'h0001;
        cap_moved <= cap_moved | (result_word_out != cap_word);
      end else if (gate_q) begin
        cap_valid <= 1'b1;
      end
    end
  end
endmodule

// file: verilog/pros_params.svh
// Purpose: offsets, field positions, reset values and counts of the sequencer
// Assumes: byte addresses on a 32-bit AHB-Lite slave
// Notes: included by bare name
`ifndef PROS_PARAMS_SVH
`define PROS_PARAMS_SVH
`define PROS_OFS_CTRL 8'h00
`define PROS_OFS_SRCEN 8'h04
`define PROS_OFS_SRCNG 8'h08
`define PROS_OFS_DCFG 8'h0C
`define PROS_OFS_JCFG 8'h10
`define PROS_OFS_JNG 8'h14
`define PROS_OFS_GDLY 8'h18
`define PROS_OFS_GWID 8'h1C
`define PROS_OFS_OCYC 8'h20
`define PROS_OFS_STAT 8'h24
`define PROS_VAL_BIT 7
`define PROS_RST_CTRL 6'h13
`define PROS_RST_SRCEN 5'h1F
`define PROS_RST_GDLY 16'h0064
`define PROS_RST_GWID 16'h00C8
`define PROS_RST_OCYC 16'h01F4
`define PROS_QDEPTH 64
`define PROS_NEXPR 32
`define PROS_IDX_J0 6'h20
`define PROS_IDX_J1 6'h21
`define PROS_MAX_WORDS 6'h22
`define PROS_SAT_MAX 16'h7FFF
`define PROS_SAT_MIN 16'h8000
`define PROS_ROUND_HALF 33'h0_0000_8000
`define PROS_HSIZE_WORD 3'h2
`endif

// file: verilog/pros_pkg.sv
// Purpose: types shared by the result output sequencer
// Assumes: nothing
// Notes: constants live in pros_params.svh
package pros_pkg;
  typedef enum logic [2:0] {
    M_IDLE = 3'h1,
    M_RUN = 3'h2,
    M_PACK = 3'h4
  } pros_mstate_t;

  typedef enum logic [1:0] {
    PH_IMAGE = 2'h0,
    PH_MEAS = 2'h1,
    PH_DISP = 2'h2
  } pros_phase_t;

  typedef struct packed {
    logic [1:0] phase_sel;
    logic judge_on_ok;
    logic overall_on_ok;
    logic judge_en;
    logic data_en;
  } pros_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
  } pros_req_t;
endpackage

// file: verilog/pros_sequencer.sv
// Purpose: parallel result word, overall line and gate strobe sequencer
// Assumes: one clock, synchronous inputs, software loads results over AHB-Lite
// Notes: values are signed 16.16 fixed point, one word per expression
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "pros_params.svh"

module pros_sequencer #(
  parameter int QDEPTH = `PROS_QDEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic measure_trigger,
  input wire logic adjustment_mode,
  input wire logic image_done,
  input wire logic measure_done,
  input wire logic display_done,
  output logic meas_start,
  output logic [15:0] result_word_out,
  output logic overall_out,
  output logic gate_out,
  output logic queue_full
);
  localparam int CW = $clog2(QDEPTH + 1);
  localparam int PW = $clog2(QDEPTH);

  pros_pkg::pros_req_t req_q;
  pros_pkg::pros_ctrl_t ctrl_q;
  pros_pkg::pros_mstate_t st_q;
  logic addr_ph;
  logic hready_q, hresp_q;
  logic [31:0] hrdata_q, rd_mux;
  logic [4:0] src_en_q, src_ng_q;
  logic [31:0] dcfg_q, jcfg_q, jng_q, jbits;
  logic [15:0] gdly_q, gwid_q, ocyc_q;
  logic [31:0] val_q [`PROS_NEXPR];
  logic measure_trigger_q, start_q, overall_q, phase_done, ng, done_ok;
  logic [5:0] idx_q;
  logic [31:0] cur_val;
  logic [32:0] rsum;
  logic [16:0] rnd;
  logic [15:0] sat_word, push_word;
  logic push_data, push_j0, push_j1, push_req, push, advance;
  logic [15:0] q_mem [QDEPTH];
  logic [PW-1:0] wptr_q, rptr_q;
  logic [CW-1:0] cnt_q, cnt_d;
  logic q_full_q, pop;
  logic busy_q, gate_q, cyc_end, nx_busy, gate_d;
  logic [15:0] ocnt_q, nx_cnt, word_q, dly_eff, cyc_eff;
  logic [16:0] gate_end;

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = hresp_q;
  assign meas_start = start_q;
  assign result_word_out = word_q;
  assign overall_out = overall_q;
  assign gate_out = gate_q;
  assign queue_full = q_full_q;

  // Bus slave: writes land with zero wait, reads take one wait state
  assign addr_ph = hsel && htrans[1] && hready;

  always_ff @(posedge clk) begin
    if (reset) begin
      req_q <= '0;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      req_q.wr <= addr_ph && hwrite && (hsize == `PROS_HSIZE_WORD);
      req_q.rd <= addr_ph && !hwrite;
      if (addr_ph) begin
        req_q.addr <= haddr[7:0];
      end
      hready_q <= !(addr_ph && !hwrite);
      hresp_q <= 1'b0;
      if (req_q.rd) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (req_q.addr[`PROS_VAL_BIT]) begin
      rd_mux = val_q[req_q.addr[6:2]];
    end else begin
      case (req_q.addr)
        `PROS_OFS_CTRL: rd_mux = {26'h0, ctrl_q};
        `PROS_OFS_SRCEN: rd_mux = {27'h0, src_en_q};
        `PROS_OFS_SRCNG: rd_mux = {27'h0, src_ng_q};
        `PROS_OFS_DCFG: rd_mux = dcfg_q;
        `PROS_OFS_JCFG: rd_mux = jcfg_q;
        `PROS_OFS_JNG: rd_mux = jng_q;
        `PROS_OFS_GDLY: rd_mux = {16'h0000, gdly_q};
        `PROS_OFS_GWID: rd_mux = {16'h0000, gwid_q};
        `PROS_OFS_OCYC: rd_mux = {16'h0000, ocyc_q};
        `PROS_OFS_STAT: rd_mux = {16'h0000, 8'(cnt_q), 4'h0, overall_q, cnt_q == '0, q_full_q, st_q != pros_pkg::M_IDLE};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `PROS_RST_CTRL;
      src_en_q <= `PROS_RST_SRCEN;
      src_ng_q <= 5'h00;
      dcfg_q <= 32'h0000_0000;
      jcfg_q <= 32'h0000_0000;
      jng_q <= 32'h0000_0000;
      gdly_q <= `PROS_RST_GDLY;
      gwid_q <= `PROS_RST_GWID;
      ocyc_q <= `PROS_RST_OCYC;
    end else if (req_q.wr && !req_q.addr[`PROS_VAL_BIT]) begin
      case (req_q.addr)
        `PROS_OFS_CTRL: ctrl_q <= hwdata[5:0];
        `PROS_OFS_SRCEN: src_en_q <= hwdata[4:0];
        `PROS_OFS_SRCNG: src_ng_q <= hwdata[4:0];
        `PROS_OFS_DCFG: dcfg_q <= hwdata;
        `PROS_OFS_JCFG: jcfg_q <= hwdata;
        `PROS_OFS_JNG: jng_q <= hwdata;
        `PROS_OFS_GDLY: gdly_q <= hwdata[15:0];
        `PROS_OFS_GWID: gwid_q <= hwdata[15:0];
        `PROS_OFS_OCYC: ocyc_q <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Expression values, one word each
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `PROS_NEXPR; i++) begin
        val_q[i] <= 32'h0000_0000;
      end
    end else if (req_q.wr && req_q.addr[`PROS_VAL_BIT]) begin
      val_q[req_q.addr[6:2]] <= hwdata;
    end
  end

  // Measurement control
  always_comb begin
    unique case (ctrl_q.phase_sel)
      pros_pkg::PH_IMAGE: phase_done = image_done;
      pros_pkg::PH_MEAS: phase_done = measure_done;
      pros_pkg::PH_DISP: phase_done = display_done;
      default: phase_done = display_done;
    endcase
  end

  assign done_ok = (st_q == pros_pkg::M_RUN) && phase_done && !adjustment_mode;
  assign advance = !push_req || !q_full_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= pros_pkg::M_IDLE;
      measure_trigger_q <= 1'b0;
      start_q <= 1'b0;
      idx_q <= 6'h00;
    end else begin
      measure_trigger_q <= measure_trigger;
      start_q <= 1'b0;
      unique case (st_q)
        pros_pkg::M_IDLE: begin
          if (measure_trigger && !measure_trigger_q && !adjustment_mode && !q_full_q) begin
            st_q <= pros_pkg::M_RUN;
            start_q <= 1'b1;
          end
        end
        pros_pkg::M_RUN: begin
          idx_q <= 6'h00;
          if (phase_done) begin
            st_q <= adjustment_mode ? pros_pkg::M_IDLE : pros_pkg::M_PACK;
          end
        end
        pros_pkg::M_PACK: begin
          if (advance) begin
            idx_q <= 6'(idx_q + 6'h01);
            if (idx_q == `PROS_IDX_J1) begin
              st_q <= pros_pkg::M_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Overall judgment line
  assign ng = |(src_en_q & src_ng_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      overall_q <= 1'b0;
    end else if (done_ok) begin
      overall_q <= ctrl_q.overall_on_ok ? !ng : ng;
    end
  end

  // Word packing: values first, then up to two judgment words
  assign jbits = jcfg_q & (ctrl_q.judge_on_ok ? ~jng_q : jng_q);
  assign cur_val = val_q[idx_q[4:0]];
  assign rsum = {cur_val[31], cur_val} + `PROS_ROUND_HALF;
  assign rnd = rsum[32:16];
  assign sat_word = (rnd[16] == rnd[15]) ? rnd[15:0] : (rnd[16] ? `PROS_SAT_MIN : `PROS_SAT_MAX);

  always_comb begin
    push_data = (st_q == pros_pkg::M_PACK) && !idx_q[5] && ctrl_q.data_en && dcfg_q[idx_q[4:0]];
    push_j0 = (st_q == pros_pkg::M_PACK) && (idx_q == `PROS_IDX_J0) && ctrl_q.judge_en && |jcfg_q[15:0];
    push_j1 = (st_q == pros_pkg::M_PACK) && (idx_q == `PROS_IDX_J1) && ctrl_q.judge_en && |jcfg_q[31:16];
    push_req = push_data || push_j0 || push_j1;
    push = push_req && !q_full_q;
    if (push_data) begin
      push_word = sat_word;
    end else if (push_j0) begin
      push_word = jbits[15:0];
    end else begin
      push_word = jbits[31:16];
    end
  end

  // Result queue
  assign pop = (cnt_q != '0) && (!busy_q || cyc_end);
  assign cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));

  always_ff @(posedge clk) begin
    if (reset) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      q_full_q <= 1'b0;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == PW'(QDEPTH - 1)) ? '0 : PW'(wptr_q + 1'b1);
      end
      if (pop) begin
        rptr_q <= (rptr_q == PW'(QDEPTH - 1)) ? '0 : PW'(rptr_q + 1'b1);
      end
      cnt_q <= cnt_d;
      q_full_q <= cnt_d == CW'(QDEPTH);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      q_mem[wptr_q] <= push_word;
    end
  end

  // Output cycle, gate delay and gate width
  assign dly_eff = (gdly_q == 16'h0000) ? 16'h0001 : gdly_q;
  assign cyc_eff = (ocyc_q == 16'h0000) ? 16'h0001 : ocyc_q;
  assign cyc_end = busy_q && (ocnt_q == 16'(cyc_eff - 16'h0001));
  assign nx_busy = pop || (busy_q && !cyc_end);
  assign nx_cnt = pop ? 16'h0000 : 16'(ocnt_q + 16'h0001);
  assign gate_end = {1'b0, dly_eff} + {1'b0, gwid_q};
  assign gate_d = nx_busy && (nx_cnt >= dly_eff) && ({1'b0, nx_cnt} < gate_end);

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      ocnt_q <= 16'h0000;
      word_q <= 16'h0000;
      gate_q <= 1'b0;
    end else begin
      busy_q <= nx_busy;
      ocnt_q <= nx_busy ? nx_cnt : 16'h0000;
      gate_q <= gate_d;
      if (pop) begin
        word_q <= q_mem[rptr_q];
      end
    end
  end

  // Checks
  logic [15:0] glen_q, gap_q;
  logic [5:0] npush_q;
  logic cfg_ok;
  logic [32:0] rerr;
  assign cfg_ok = (gate_end < {1'b0, cyc_eff}) && (gwid_q != 16'h0000);
  assign rerr = 33'({cur_val[31], cur_val} - {push_word[15], push_word, 16'h0000});

  always_ff @(posedge clk) begin
    if (reset) begin
      glen_q <= 16'h0000;
      gap_q <= 16'h0000;
      npush_q <= 6'h00;
    end else begin
      glen_q <= gate_q ? 16'(glen_q + 16'h0001) : 16'h0000;
      if (pop) begin
        gap_q <= 16'h0001;
      end else if (gap_q != 16'hFFFF) begin
        gap_q <= 16'(gap_q + 16'h0001);
      end
      if (st_q == pros_pkg::M_RUN) begin
        npush_q <= 6'h00;
      end else if (push) begin
        npush_q <= 6'(npush_q + 6'h01);
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_rise;
    !measure_trigger ##1 measure_trigger;
  endsequence

  sequence s_load;
    pop ##1 1'b1;
  endsequence

  trigger_start_a: assert property (
    (s_rise ##0 (st_q == pros_pkg::M_IDLE && !adjustment_mode && !q_full_q)) |=> meas_start
  ) else $error("accepted trigger edge gave no start pulse");

  adjust_block_a: assert property (
    meas_start |-> $past(!adjustment_mode) && $past(measure_trigger) && !$past(measure_trigger_q)
  ) else $error("start without operating mode trigger edge");

  full_refuse_a: assert property (
    queue_full |=> !meas_start
  ) else $error("start while queue full");

  overall_hold_a: assert property (
    $changed(overall_out) |-> $past(done_ok)
  ) else $error("overall line changed without completed measurement");

  gate_settle_a: assert property (
    s_load |-> !gate_out ##1 (!gate_out || $past(dly_eff) == 16'h0001)
  ) else $error("gate high right after word change");

  gate_width_a: assert property (
    ($fell(gate_out) && $past(cfg_ok) && $stable(gwid_q)) |-> glen_q == gwid_q
  ) else $error("gate width wrong");

  cycle_gap_a: assert property (
    (pop && busy_q && cfg_ok && $stable(ocyc_q)) |-> gap_q == cyc_eff
  ) else $error("output cycle interval wrong");

  saturate_a: assert property (
    (push_data && rnd[16] != rnd[15]) |-> push_word == (cur_val[31] ? 16'h8000 : 16'h7FFF)
  ) else $error("value not saturated");

  round_near_a: assert property (
    (push_data && rnd[16] == rnd[15]) |-> ($signed(rerr) >= -33'sd32768 && $signed(rerr) < 33'sd32768)
  ) else $error("value not rounded to nearest");

  judge_unset_a: assert property (
    push_j0 |-> (push_word & ~jcfg_q[15:0]) == 16'h0000
  ) else $error("judgment bit for unset expression");

  word_limit_a: assert property (
    npush_q <= `PROS_MAX_WORDS
  ) else $error("too many words for one measurement");
endmodule
